// ==== rtl/wws_top.sv ====
/*
 * Window watchdog with supply-supervisor reset gating.
 * Assumes supply comparators, timing pin sense and charge trip come in as
 * asynchronous digital levels; open-drain pins are resolved outside.
 */
`timescale 1ns/1ps

// Summary of operation
// - below power-on floor reset is undefined; reset is simply held asserted.
// - between floor and minimum supply, reset low and fault output released.
// - whenever reset is asserted the fault output is released.
// - above minimum supply, reset follows undervoltage comparison with hysteresis.
// - fault driven low on kick interval shorter than lower or longer than upper.
// - floating or pulled-up timing pin picks presets; a capacitor picks measured bounds.
// - floating pin with enable high gives 800 ms lower and 1600 ms upper.
// - pulled-up pin with enable high gives 1.85 ms lower and 11.0 ms upper.
// - enable low disables watchdog and keeps fault output released.
// - capacitor charged by constant current to trip level times the window.
// - capacitor upper bound is 77.4 s per microfarad plus 0.055 s.
// - capacitor lower bound is half the upper bound.
// - first kick after reset or enable is checked against the upper bound only.
// - timing pin configuration is re-detected after each reset, within 381 us.
// - kick changes ignored for 150 us after enable rises.
// - kick ignored while reset asserted; checking resumes afterwards.
module wws_top #(
    parameter int CNT_W            = 32,
    parameter int CHG_W            = 32,
    parameter int FLOAT_LOWER_CYC  = wws_pkg::FLOAT_LOWER_CYC,
    parameter int FLOAT_UPPER_CYC  = wws_pkg::FLOAT_UPPER_CYC,
    parameter int PULLUP_LOWER_CYC = wws_pkg::PULLUP_LOWER_CYC,
    parameter int PULLUP_UPPER_CYC = wws_pkg::PULLUP_UPPER_CYC,
    parameter int SETUP_CYC        = wws_pkg::SETUP_CYC,
    parameter int DETECT_CYC       = wws_pkg::DETECT_CYC,
    parameter int CAP_OFFSET_CYC   = wws_pkg::CAP_OFFSET_CYC
) (
    input  wire logic CLOCK_I,
    input  wire logic RST_I,
    input  wire logic SUPPLY_POR_OK_I,
    input  wire logic SUPPLY_MIN_OK_I,
    input  wire logic SUPPLY_BELOW_UV_I,
    input  wire logic SUPPLY_ABOVE_HYST_I,
    input  wire logic KICK_INPUT_I,
    input  wire logic WATCHDOG_ENABLE_PIN_I,
    input  wire logic TIMING_SELECT_PIN_I,
    input  wire logic TIMING_CAP_TRIP_I,
    output logic      TIMING_CHARGE_EN_O,
    output logic      RESET_O,
    output logic      RESET_OE_O,
    output logic      WINDOW_FAULT_OUTPUT_O,
    output logic      WINDOW_FAULT_OE_O
);

    localparam int NPIN = $bits(wws_pkg::wws_pins_t);

    // pin synchroniser: three stages, change accepted when stages two and three agree
    wws_pkg::wws_pins_t pins_raw;
    wws_pkg::wws_pins_t pin;
    logic [NPIN-1:0]    s1_q;
    logic [NPIN-1:0]    s2_q;
    logic [NPIN-1:0]    s3_q;
    logic [NPIN-1:0]    flt_q;

    assign pins_raw = '{supply_por_ok:       SUPPLY_POR_OK_I,
                        supply_min_ok:       SUPPLY_MIN_OK_I,
                        supply_below_uv:     SUPPLY_BELOW_UV_I,
                        supply_above_hyst:   SUPPLY_ABOVE_HYST_I,
                        kick_input:          KICK_INPUT_I,
                        watchdog_enable_pin: WATCHDOG_ENABLE_PIN_I,
                        timing_select_pin:   TIMING_SELECT_PIN_I,
                        timing_cap_trip:     TIMING_CAP_TRIP_I};

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_sync
            always_ff @(posedge CLOCK_I or posedge RST_I) begin
                if (RST_I) begin
                    s1_q[g]  <= 1'b0;
                    s2_q[g]  <= 1'b0;
                    s3_q[g]  <= 1'b0;
                    flt_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= pins_raw[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g]) begin
                        flt_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

    assign pin = flt_q;

    // supply supervisor
    logic uv_hold_q;
    logic uv_hold_d;
    logic rst_as;

    assign uv_hold_d = pin.supply_below_uv ? 1'b1 :
                       pin.supply_above_hyst ? 1'b0 : uv_hold_q;
    assign rst_as    = !pin.supply_por_ok | !pin.supply_min_ok | uv_hold_q;

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            uv_hold_q <= 1'b1;
        end else begin
            uv_hold_q <= uv_hold_d;
        end
    end

    // timing pin detection
    wws_pkg::wws_det_t  st_q;
    wws_pkg::wws_det_t  st_d;
    wws_pkg::wws_mode_t mode_q;
    logic [CHG_W-1:0]   chg_q;
    logic [CNT_W-1:0]   lower_q;
    logic [CNT_W-1:0]   upper_q;
    logic               cap_seen_q;
    logic [CHG_W+15:0]  cap_prod;
    logic [CNT_W-1:0]   cap_upper;
    logic               is_float;
    logic               detect_late;

    assign cap_prod    = chg_q * 16'(wws_pkg::CAP_GAIN_Q);
    assign cap_upper   = CNT_W'(cap_prod >> wws_pkg::CAP_GAIN_SHIFT)
                         + CNT_W'(CAP_OFFSET_CYC);
    assign is_float    = chg_q < CHG_W'(wws_pkg::FLOAT_MAX_CYC);
    assign detect_late = chg_q >= CHG_W'(DETECT_CYC);

    always_comb begin
        st_d = st_q;
        case (st_q)
            wws_pkg::ST_IDLE:   if (!rst_as) st_d = wws_pkg::ST_SENSE;
            wws_pkg::ST_SENSE:  st_d = pin.timing_select_pin ? wws_pkg::ST_READY
                                                               : wws_pkg::ST_CHARGE;
            wws_pkg::ST_CHARGE: if (pin.timing_cap_trip) st_d = wws_pkg::ST_READY;
            wws_pkg::ST_READY:  st_d = wws_pkg::ST_READY;
            default:            st_d = wws_pkg::ST_IDLE;
        endcase
        if (rst_as) begin
            st_d = wws_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            st_q       <= wws_pkg::ST_IDLE;
            mode_q     <= wws_pkg::MODE_FLOAT;
            chg_q      <= '0;
            lower_q    <= CNT_W'(FLOAT_LOWER_CYC);
            upper_q    <= CNT_W'(FLOAT_UPPER_CYC);
            cap_seen_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (st_q == wws_pkg::ST_SENSE) begin
                chg_q      <= '0;
                cap_seen_q <= 1'b0;
                if (pin.timing_select_pin) begin
                    mode_q  <= wws_pkg::MODE_PULLUP;
                    lower_q <= CNT_W'(PULLUP_LOWER_CYC);
                    upper_q <= CNT_W'(PULLUP_UPPER_CYC);
                end
            end else if (st_q == wws_pkg::ST_CHARGE) begin
                if (!(&chg_q)) begin
                    chg_q <= chg_q + 1'b1;
                end
                // still charging at the detection limit: must be a capacitor
                if (detect_late) begin
                    cap_seen_q <= 1'b1;
                    mode_q     <= wws_pkg::MODE_CAP;
                end
                if (pin.timing_cap_trip) begin
                    if (is_float && !cap_seen_q) begin
                        mode_q  <= wws_pkg::MODE_FLOAT;
                        lower_q <= CNT_W'(FLOAT_LOWER_CYC);
                        upper_q <= CNT_W'(FLOAT_UPPER_CYC);
                    end else begin
                        mode_q  <= wws_pkg::MODE_CAP;
                        lower_q <= cap_upper >> wws_pkg::LOWER_SHIFT;
                        upper_q <= cap_upper;
                    end
                end
            end
        end
    end

    // enable and setup guard
    logic              en_prev_q;
    logic [15:0]       setup_q;
    logic              en_rise;

    assign en_rise = pin.watchdog_enable_pin & !en_prev_q;

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            en_prev_q <= 1'b0;
            setup_q   <= '0;
        end else begin
            en_prev_q <= pin.watchdog_enable_pin;
            if (en_rise) begin
                setup_q <= 16'(SETUP_CYC);
            end else if (setup_q != '0) begin
                setup_q <= setup_q - 1'b1;
            end
        end
    end

    // window checker
    logic             kick_prev_q;
    logic             first_q;
    logic             fault_q;
    logic [CNT_W-1:0] cnt_q;
    logic             wd_active;
    logic             kick_ok;
    logic             early;
    logic             late;

    // enable edge itself is inside the setup guard, before the counter loads
    assign wd_active = !rst_as & pin.watchdog_enable_pin & !en_rise
                       & (st_q == wws_pkg::ST_READY) & (setup_q == '0);
    assign kick_ok   = kick_prev_q & !pin.kick_input & wd_active;
    assign early     = !first_q & (cnt_q < lower_q);
    assign late      = cnt_q >= upper_q;

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            kick_prev_q <= 1'b1;
            first_q     <= 1'b1;
            fault_q     <= 1'b0;
            cnt_q       <= '0;
        end else begin
            kick_prev_q <= pin.kick_input;
            if (!wd_active) begin
                first_q <= 1'b1;
                fault_q <= 1'b0;
                cnt_q   <= '0;
            end else if (kick_ok) begin
                first_q <= 1'b0;
                fault_q <= early;
                cnt_q   <= '0;
            end else if (late) begin
                first_q <= 1'b1;
                fault_q <= 1'b1;
                cnt_q   <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    // open-drain outputs only ever pull low
    assign RESET_O               = 1'b0;
    assign RESET_OE_O            = rst_as;
    assign WINDOW_FAULT_OUTPUT_O = 1'b0;
    assign WINDOW_FAULT_OE_O     = fault_q & !rst_as;
    assign TIMING_CHARGE_EN_O    = (st_q == wws_pkg::ST_CHARGE);

    // checks
    fault_rel_rst_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        rst_as |-> !WINDOW_FAULT_OE_O) else $error("fault driven during reset");

    low_supply_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        !pin.supply_min_ok |-> RESET_OE_O && !WINDOW_FAULT_OE_O)
        else $error("reset not held below minimum supply");

    uv_hyst_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        pin.supply_min_ok && pin.supply_below_uv |=> RESET_OE_O)
        else $error("reset missed undervoltage");

    wd_disabled_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        !pin.watchdog_enable_pin |=> !WINDOW_FAULT_OE_O)
        else $error("fault while watchdog disabled");

    early_kick_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        kick_ok && !first_q && cnt_q < lower_q |=> fault_q)
        else $error("early kick not flagged");

    late_kick_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        wd_active && !kick_ok && cnt_q >= upper_q |=> fault_q && cnt_q == '0)
        else $error("missed kick not flagged");

    first_kick_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        kick_ok && first_q |=> !fault_q) else $error("first kick checked early");

    setup_ign_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        en_rise |=> !kick_ok [*8]) else $error("kick taken during setup");

    reset_ign_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        rst_as |-> !kick_ok ##1 first_q) else $error("kick taken in reset");

    restart_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        kick_ok |=> cnt_q == '0 ##1 cnt_q == CNT_W'(1))
        else $error("interval count not restarted");

    redetect_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        $fell(rst_as) |-> st_q == wws_pkg::ST_IDLE ##1 st_q == wws_pkg::ST_SENSE)
        else $error("pin detection not restarted");

    pullup_sel_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        st_q == wws_pkg::ST_SENSE && pin.timing_select_pin && !rst_as
        |=> upper_q == CNT_W'(PULLUP_UPPER_CYC) && lower_q == CNT_W'(PULLUP_LOWER_CYC))
        else $error("pull-up preset not loaded");

    cap_half_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        st_q == wws_pkg::ST_READY && mode_q == wws_pkg::MODE_CAP
        |-> lower_q == (upper_q >> wws_pkg::LOWER_SHIFT))
        else $error("capacitor lower bound not half");

endmodule

// ==== rtl/wws_pkg.sv ====
/*
 * Shared constants and types for the window watchdog supervisor.
 * Assumes a 40 MHz core clock; pin levels arrive as digital comparator outputs.
 */
package wws_pkg;

    // core clock
    localparam int CLK_HZ      = 40_000_000;
    localparam int CLK_PER_US  = CLK_HZ / 1_000_000;

    // factory preset windows, typical figures in microseconds
    localparam int FLOAT_LOWER_US  = 800_000;
    localparam int FLOAT_UPPER_US  = 1_600_000;
    localparam int PULLUP_LOWER_US = 1_850;
    localparam int PULLUP_UPPER_US = 11_000;
    localparam int FLOAT_LOWER_CYC  = FLOAT_LOWER_US * CLK_PER_US;
    localparam int FLOAT_UPPER_CYC  = FLOAT_UPPER_US * CLK_PER_US;
    localparam int PULLUP_LOWER_CYC = PULLUP_LOWER_US * CLK_PER_US;
    localparam int PULLUP_UPPER_CYC = PULLUP_UPPER_US * CLK_PER_US;

    // enable setup and pin detection times
    localparam int SETUP_US   = 150;
    localparam int SETUP_CYC  = SETUP_US * CLK_PER_US;
    localparam int DETECT_US  = 381;
    localparam int DETECT_CYC = DETECT_US * CLK_PER_US;

    // capacitor mode: upper = slope * C + offset, C seen through charge time
    localparam real CAP_SLOPE_S_PER_UF = 77.4;
    localparam real CHARGE_CURRENT_NA  = 375.0;
    localparam real CHARGE_TRIP_V      = 1.21;
    localparam int  CAP_OFFSET_US      = 55_000;
    localparam int  CAP_OFFSET_CYC     = CAP_OFFSET_US * CLK_PER_US;
    localparam int  CAP_GAIN_SHIFT     = 10;
    localparam int  CAP_GAIN_Q =
        int'(CAP_SLOPE_S_PER_UF * CHARGE_CURRENT_NA / CHARGE_TRIP_V / 1000.0 * 1024.0);
    localparam int  LOWER_SHIFT        = 1;
    // a bare pin trips far sooner than the smallest supported capacitor
    localparam int  FLOAT_MAX_US       = 10;
    localparam int  FLOAT_MAX_CYC      = FLOAT_MAX_US * CLK_PER_US;

    localparam int  SYNC_STAGES        = 3;

    typedef struct packed {
        logic supply_por_ok;
        logic supply_min_ok;
        logic supply_below_uv;
        logic supply_above_hyst;
        logic kick_input;
        logic watchdog_enable_pin;
        logic timing_select_pin;
        logic timing_cap_trip;
    } wws_pins_t;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_SENSE  = 4'h2,
        ST_CHARGE = 4'h4,
        ST_READY  = 4'h8
    } wws_det_t;

    typedef enum logic [1:0] {
        MODE_FLOAT  = 2'h0,
        MODE_PULLUP = 2'h1,
        MODE_CAP    = 2'h2
    } wws_mode_t;

endpackage

// ==== testbench/wws_host_model.sv ====
/*
 * Host kick driver and timing pin model for the watchdog supervisor bench.
 * Assumes the bench asks for each kick with a one-cycle request and sets
 * how many cycles the timing pin takes to reach its trip level.
 */
`timescale 1ns/1ps

module wws_host_model (
    input  wire logic        clk_i,
    input  wire logic        kick_req_i,
    input  wire logic        charge_en_i,
    input  wire logic [15:0] trip_delay_i,
    output logic             kick_o,
    output logic             cap_trip_o
);
    logic [3:0]  low_cnt_q;
    logic [15:0] chg_cnt_q;

    initial begin
        kick_o     = 1'b1;
        cap_trip_o = 1'b0;
        low_cnt_q  = 4'h0;
        chg_cnt_q  = 16'h0;
    end

    // falling edge per request, held low long enough to pass the filter
    always @(posedge clk_i) begin
        if (kick_req_i) begin
            kick_o    <= 1'b0;
            low_cnt_q <= 4'h8;
        end else if (low_cnt_q > 4'h1) begin
            low_cnt_q <= low_cnt_q - 4'h1;
        end else begin
            low_cnt_q <= 4'h0;
            kick_o    <= 1'b1;
        end
    end

    // pin ramps only while the source is on, discharged otherwise
    always @(posedge clk_i) begin
        if (!charge_en_i) begin
            chg_cnt_q  <= 16'h0;
            cap_trip_o <= 1'b0;
        end else begin
            chg_cnt_q  <= chg_cnt_q + 16'h1;
            cap_trip_o <= (chg_cnt_q >= trip_delay_i);
        end
    end
endmodule

// ==== testbench/tb_window_watchdog_supervisor.sv ====
/*
 * Self-checking bench for the window watchdog supervisor top.
 * Assumes shortened window parameters and the host model beside it.
 */
`timescale 1ns/1ps

module tb_window_watchdog_supervisor;
    localparam int LO_P = 100;
    localparam int UP_P = 600;
    localparam int LO_F = 400;
    localparam int UP_F = 800;
    localparam int COFS = 50;

    logic        clk        = 1'b0;
    logic        rst        = 1'b1;
    logic        por_ok     = 1'b1;
    logic        min_ok     = 1'b1;
    logic        below_uv   = 1'b0;
    logic        above_hyst = 1'b1;
    logic        en         = 1'b1;
    logic        sel        = 1'b1;
    logic        kick_req   = 1'b0;
    logic [15:0] trip_dly   = 16'h0014;
    logic [31:0] seed       = 32'h0000dd94;
    logic        kick;
    logic        trip;
    logic        chg_en;
    logic        rst_oe;
    logic        flt_oe;
    logic        rst_do;
    logic        flt_do;
    int          fail_count  = 0;
    int          check_count = 0;

    always #12.5 clk = ~clk;

    wws_top #(
        .FLOAT_LOWER_CYC  (LO_F),
        .FLOAT_UPPER_CYC  (UP_F),
        .PULLUP_LOWER_CYC (LO_P),
        .PULLUP_UPPER_CYC (UP_P),
        .SETUP_CYC        (20),
        .DETECT_CYC       (5000),
        .CAP_OFFSET_CYC   (COFS)
    ) i_dut (
        .CLOCK_I               (clk),
        .RST_I                 (rst),
        .SUPPLY_POR_OK_I       (por_ok),
        .SUPPLY_MIN_OK_I       (min_ok),
        .SUPPLY_BELOW_UV_I     (below_uv),
        .SUPPLY_ABOVE_HYST_I   (above_hyst),
        .KICK_INPUT_I          (kick),
        .WATCHDOG_ENABLE_PIN_I (en),
        .TIMING_SELECT_PIN_I   (sel),
        .TIMING_CAP_TRIP_I     (trip),
        .TIMING_CHARGE_EN_O    (chg_en),
        .RESET_O               (rst_do),
        .RESET_OE_O            (rst_oe),
        .WINDOW_FAULT_OUTPUT_O (flt_do),
        .WINDOW_FAULT_OE_O     (flt_oe)
    );

    wws_host_model i_host (
        .clk_i        (clk),
        .kick_req_i   (kick_req),
        .charge_en_i  (chg_en),
        .trip_delay_i (trip_dly),
        .kick_o       (kick),
        .cap_trip_o   (trip)
    );

    function automatic int pick(input int lo, input int span);
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return lo + (int'(seed[15:0]) % span);
    endfunction

    // charge time to capacitance, then slope plus offset, in cycles
    function automatic int cap_up(input int d);
        return int'(77.4 * 0.375 * real'(d) / 1.21) + COFS;
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic seen, input logic exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic gap(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // kick now, judge the interval since the previous kick, idle n cycles
    task automatic kick_gap(input int n, input logic exp);
        kick_req = 1'b1;
        gap(1);
        kick_req = 1'b0;
        gap(9);
        check("fault_oe", flt_oe, exp);
        gap(n - 10);
    endtask

    task automatic run_window(input int lo, input int up, input int m);
        kick_gap(pick(lo + m, up - lo - 3 * m), 1'b0);
        kick_gap(lo - m, 1'b0);
        kick_gap(lo + m, 1'b1);
        kick_gap(up - 3 * m, 1'b0);
        kick_gap(pick(lo + m, up - lo - 3 * m), 1'b0);
        kick_gap(up - m, 1'b0);
        check("fault_oe", flt_oe, 1'b0);
        gap(2 * m + 10);
        check("fault_oe", flt_oe, 1'b1);
        kick_gap(lo + m, 1'b0);
    endtask

    task automatic restart(input logic pin, input int d);
        sel      = pin;
        trip_dly = 16'(d);
        rst      = 1'b1;
        gap(3);
        rst = 1'b0;
        gap(12);
        check("charge_en", chg_en, !pin);
        gap(d + 88);
        check("charge_en", chg_en, 1'b0);
    endtask

    initial begin
        int d;
        gap(3);
        check("reset_oe", rst_oe, 1'b1);
        check("reset_data", rst_do, 1'b0);
        check("fault_data", flt_do, 1'b0);
        check("fault_oe", flt_oe, 1'b0);
        rst = 1'b0;
        gap(8);
        check("reset_oe", rst_oe, 1'b0);
        gap(60);
        run_window(LO_P, UP_P, 8);
        kick_gap(30, 1'b0);
        kick_gap(200, 1'b1);
        en = 1'b0;
        gap(10);
        check("fault_oe", flt_oe, 1'b0);
        kick_gap(30, 1'b0);
        kick_gap(30, 1'b0);
        en = 1'b1;
        gap(2);
        kick_gap(40, 1'b0);
        kick_gap(50, 1'b0);
        kick_gap(150, 1'b1);
        below_uv   = 1'b1;
        above_hyst = 1'b0;
        gap(8);
        check("reset_oe", rst_oe, 1'b1);
        check("fault_oe", flt_oe, 1'b0);
        kick_gap(20, 1'b0);
        kick_gap(20, 1'b0);
        min_ok = 1'b0;
        gap(8);
        check("reset_oe", rst_oe, 1'b1);
        check("fault_oe", flt_oe, 1'b0);
        min_ok   = 1'b1;
        below_uv = 1'b0;
        gap(12);
        check("reset_oe", rst_oe, 1'b1);
        above_hyst = 1'b1;
        gap(8);
        check("reset_oe", rst_oe, 1'b0);
        gap(100);
        kick_gap(50, 1'b0);
        kick_gap(100, 1'b1);
        restart(1'b0, 20);
        run_window(LO_F, UP_F, 8);
        d = pick(430, 40);
        restart(1'b0, d);
        run_window(cap_up(d) / 2, cap_up(d), cap_up(d) / 20);
        final_report();
    end

    // hang guard, well past the longest expected run
    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        final_report();
    end
endmodule
